// File: core/srap_device.sv
// Purpose: slave register access port, controller end
// Assumes: host keeps its own spacing of select and strobe
// Notes: register file sits outside, behind rd_ and wr_ ports
`timescale 1ns/1ps
`default_nettype none
module srap_device
  import srap_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  srap_if.device bus,
  input wire logic master_active,
  input wire logic master_release,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  output logic wr_stb,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MASTER,
    ST_PREP,
    ST_ACK,
    ST_DONE
  } srap_state_t;

  srap_state_t state;
  srap_state_t next_state;
  logic [2:0] cs_sync;
  logic [2:0] sas_sync;
  logic cs_q;
  logic sas_q;
  logic cs_now;
  logic sas_now;
  logic cs_rise;
  logic sas_rise;
  logic sas_fall;
  logic mode68;
  logic cap;
  logic start;
  logic end86;
  logic do_ack;
  logic read_now;
  logic is_read;
  logic [ADDR_W-1:0] addr_reg;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term;
  logic in_cycle;

  // async pins: three stages, a change counts when the last two agree
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_sync <= SYNC_RESET;
      sas_sync <= SYNC_RESET;
    end
    else if (ce)
    begin
      cs_sync <= {cs_sync[1:0], bus.cs_n};
      sas_sync <= {sas_sync[1:0], bus.slave_addr_strobe};
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_q <= 1'b1;
      sas_q <= 1'b1;
    end
    else if (ce)
    begin
      cs_q <= cs_now;
      sas_q <= sas_now;
    end
  end

  assign cs_now = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_q;
  assign sas_now = (sas_sync[1] == sas_sync[2]) ? sas_sync[2] : sas_q;
  assign cs_rise = cs_now & ~cs_q;
  assign sas_rise = sas_now & ~sas_q;
  assign sas_fall = ~sas_now & sas_q;
  // mode pin is meant to be strapped; changing it mid-cycle is undefined
  assign mode68 = bus.bus_protocol_select;

  assign cap = mode68 ? sas_fall : sas_rise;
  // x86: strobe rise with select low; 68k: both low, level
  assign start = mode68 ? (~cs_now & ~sas_now)
                        : (~cs_now & sas_rise);
  assign end86 = sas_fall | cs_rise;
  assign read_now = cap ? (mode68 ? bus.rw : ~bus.rw) : is_read;
  // live pins at the capture edge so x86 reads can answer at once
  assign rd_addr = cap ? bus.reg_addr : addr_reg;
  assign term = mode68 ? CNT_W'(DSACK_DELAY_CLKS - 1)
                       : CNT_W'(RDY_DELAY_CLKS - 1);
  assign in_cycle = (next_state == ST_ACK) || (next_state == ST_DONE);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_reg <= '0;
      is_read <= 1'b0;
    end
    else if (ce && cap)
    begin
      addr_reg <= bus.reg_addr;
      is_read <= read_now;
    end
  end

  always_comb
  begin
    next_state = state;
    do_ack = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          if (master_active)
            next_state = ST_MASTER;
          else if (mode68)
            next_state = ST_PREP;
          else
          begin
            next_state = ST_ACK;
            do_ack = 1'b1;
          end
        end
      end
      ST_MASTER:
      begin
        if (mode68 ? cs_now : end86)
          next_state = ST_IDLE;
        else if (master_release)
        begin
          next_state = ST_ACK;
          do_ack = 1'b1;
        end
      end
      ST_PREP:
      begin
        next_state = ST_ACK;
        do_ack = 1'b1;
      end
      ST_ACK:
      begin
        if (!mode68 && end86)
          next_state = ST_IDLE;
        else if (cnt == term)
          next_state = ST_DONE;
      end
      ST_DONE:
      begin
        if (mode68 ? sas_now : end86)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state <= ST_IDLE;
    else if (ce)
      state <= next_state;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if (ce)
    begin
      if (state == ST_ACK)
        cnt <= cnt + CNT_W'(1);
      else
        cnt <= '0;
    end
  end

  // acknowledge held only while this strobe's cycle lives
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      bus.slave_mem_ack_n <= 1'b1;
    else if (ce)
      bus.slave_mem_ack_n <= ~in_cycle;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.dsack_out_n <= 2'h3;
      bus.dsack_oe <= 1'b0;
    end
    else if (ce)
    begin
      if (!mode68 || next_state == ST_IDLE)
      begin
        bus.dsack_out_n <= 2'h3;
        bus.dsack_oe <= 1'b0;
      end
      else if (do_ack)
        bus.dsack_oe <= 1'b1;
      else if (state == ST_ACK && next_state == ST_DONE)
        bus.dsack_out_n <= 2'h0;
      else if (state == ST_DONE && cs_rise)
        bus.dsack_out_n <= 2'h3;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      bus.ready_out_n <= 1'b1;
    else if (ce)
      bus.ready_out_n <= ~(!mode68 && next_state == ST_DONE);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.dev_data <= '0;
      bus.dev_data_oe <= 1'b0;
    end
    else if (ce)
    begin
      if (do_ack)
      begin
        bus.dev_data <= {{(BUS_W-DATA_W){1'b0}}, rd_data};
        bus.dev_data_oe <= read_now;
      end
      else if (!in_cycle)
        bus.dev_data_oe <= 1'b0;
    end
  end

  // write lands at the same edge the 68k dsack goes low
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_stb <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end
    else if (ce)
    begin
      wr_stb <= 1'b0;
      if (state == ST_ACK && !is_read && next_state != ST_IDLE &&
          cnt == CNT_W'(WR_CAPTURE_CLKS - 1))
      begin
        wr_stb <= 1'b1;
        wr_addr <= addr_reg;
        wr_data <= bus.data[DATA_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// File: core/srap_pkg.sv
// Purpose: shared constants for the slave register access port
// Assumes: one bus clock, mclk, at 10 MHz
// Notes: delays are counted in whole bus clocks
package srap_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int BUS_W = 32;
  localparam int CNT_W = 4;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  // acknowledge to write capture and to dsack, in bus clocks
  localparam int WR_CAPTURE_CLKS = 2;
  localparam int DSACK_DELAY_CLKS = 2;
  // ready follows the acknowledge by 2.5 clocks; whole edges only
  localparam int RDY_DELAY_HALF_CLKS = 5;
  localparam int RDY_DELAY_CLKS = (RDY_DELAY_HALF_CLKS + 1) / 2;
  // select released to next select or memory request
  localparam int CS_GAP_CLKS = 2;
endpackage

// File: core/srap_if.sv
// Purpose: pins between host and register port
// Assumes: both ends on mclk
// Notes: released lines read high, as with pull-ups
`timescale 1ns/1ps
`default_nettype none
interface srap_if;
  import srap_pkg::*;
  logic bus_protocol_select;
  logic cs_n;
  logic slave_addr_strobe;
  logic rw;
  logic [ADDR_W-1:0] reg_addr;
  logic [BUS_W-1:0] host_data;
  logic host_data_oe;
  logic [BUS_W-1:0] dev_data;
  logic dev_data_oe;
  logic [BUS_W-1:0] data;
  logic slave_mem_ack_n;
  logic [1:0] dsack_out_n;
  logic dsack_oe;
  logic [1:0] data_size_ack;
  logic ready_out_n;
  assign data = dev_data_oe ? dev_data :
                host_data_oe ? host_data : {BUS_W{1'b1}};
  assign data_size_ack = dsack_oe ? dsack_out_n : 2'h3;
  modport device (
    input bus_protocol_select, cs_n, slave_addr_strobe, rw, reg_addr,
    input data,
    output dev_data, dev_data_oe, slave_mem_ack_n, dsack_out_n,
    output dsack_oe, ready_out_n
  );
  modport host (
    input bus_protocol_select, data, slave_mem_ack_n, data_size_ack,
    input ready_out_n,
    output cs_n, slave_addr_strobe, rw, reg_addr, host_data, host_data_oe
  );
endinterface
`default_nettype wire

// File: core/srap_host.sv
// Purpose: host end driving register reads and writes
// Assumes: no memory request issued from this end
// Notes: no timeout; a silent device stalls the host
`timescale 1ns/1ps
`default_nettype none
module srap_host
  import srap_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  srap_if.host bus,
  input wire logic req,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_CSLOW,
    H_RAISE,
    H_WAIT,
    H_GAP
  } srap_hstate_t;

  srap_hstate_t state;
  logic [CNT_W-1:0] gap;
  logic mode68;
  logic acked;

  assign mode68 = bus.bus_protocol_select;
  assign acked = mode68 ? (bus.data_size_ack == 2'h0)
                        : ~bus.ready_out_n;
  assign busy = (state != H_IDLE);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= H_IDLE;
      gap <= '0;
      bus.cs_n <= 1'b1;
      bus.slave_addr_strobe <= 1'b1;
      bus.rw <= 1'b1;
      bus.reg_addr <= '0;
      bus.host_data <= '0;
      bus.host_data_oe <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (req)
          begin
            bus.reg_addr <= req_addr;
            bus.rw <= mode68 ? ~req_write : req_write;
            bus.host_data <= {{(BUS_W-DATA_W){1'b0}}, req_wdata};
            bus.host_data_oe <= req_write;
            bus.slave_addr_strobe <= 1'b0;
            if (mode68)
            begin
              bus.cs_n <= 1'b0;
              state <= H_WAIT;
            end
            else
              state <= H_CSLOW;
          end
        end
        H_CSLOW:
        begin
          bus.cs_n <= 1'b0;
          state <= H_RAISE;
        end
        H_RAISE:
        begin
          bus.slave_addr_strobe <= 1'b1;
          state <= H_WAIT;
        end
        H_WAIT:
        begin
          if (acked)
          begin
            rdata <= bus.data[DATA_W-1:0];
            done <= 1'b1;
            bus.cs_n <= 1'b1;
            bus.slave_addr_strobe <= ~mode68 ? 1'b0 : 1'b1;
            bus.host_data_oe <= 1'b0;
            gap <= '0;
            state <= H_GAP;
          end
        end
        H_GAP:
        begin
          if (gap != CNT_W'(CS_GAP_CLKS))
            gap <= gap + CNT_W'(1);
          // wait for the device to drop its acknowledge as well
          if (gap == CNT_W'(CS_GAP_CLKS) && bus.slave_mem_ack_n)
            state <= H_IDLE;
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/srap_properties.sv
// Purpose: wire-level checks between host and register port
// Assumes: both ends on mclk, interface signals as plain inputs
// Notes: master waits are checked by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module srap_properties
  import srap_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic master_active,
  input wire logic bus_protocol_select,
  input wire logic cs_n,
  input wire logic slave_addr_strobe,
  input wire logic rw,
  input wire logic [BUS_W-1:0] data,
  input wire logic dev_data_oe,
  input wire logic slave_mem_ack_n,
  input wire logic dsack_oe,
  input wire logic [1:0] data_size_ack,
  input wire logic ready_out_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // direction bit flips meaning with the mode
  wire m = bus_protocol_select;
  wire rd = m ? rw : !rw;

  a_ack_68k_start: assert property (
    m && !master_active && $fell(cs_n | slave_addr_strobe)
    |-> ##4 slave_mem_ack_n ##1 !slave_mem_ack_n)
    else $error("68k acknowledge late or early");
  a_ack_x86_start: assert property (
    !m && !master_active && !cs_n && $rose(slave_addr_strobe)
    |-> ##3 slave_mem_ack_n ##1 !slave_mem_ack_n)
    else $error("x86 acknowledge late or early");
  a_dsack_after_ack: assert property (
    m && $fell(slave_mem_ack_n)
    |-> ##1 data_size_ack == 2'h3 ##1 data_size_ack == 2'h0)
    else $error("size acknowledges not two clocks after ack");
  a_ready_after_ack: assert property (
    !m && $fell(slave_mem_ack_n)
    |-> ##2 ready_out_n ##1 !ready_out_n)
    else $error("ready not three clocks after ack");
  a_read_data_drive: assert property (
    $fell(slave_mem_ack_n) |-> dev_data_oe == rd)
    else $error("data drive does not match direction at ack");
  a_end_68k_cycle: assert property (
    m && !slave_mem_ack_n && $rose(slave_addr_strobe)
    |-> ##3 !slave_mem_ack_n
    ##1 (slave_mem_ack_n && !dsack_oe && !dev_data_oe))
    else $error("68k cycle not closed after strobe rise");
  a_end_x86_cycle: assert property (
    !m && !slave_mem_ack_n && $fell(slave_addr_strobe)
    |-> ##3 !slave_mem_ack_n
    ##1 (slave_mem_ack_n && ready_out_n && !dev_data_oe))
    else $error("x86 cycle not closed after strobe fall");
  a_mode_pins_only: assert property (
    m ? ready_out_n : !dsack_oe)
    else $error("termination of the other mode driven");
  a_upper_lines_zero: assert property (
    dev_data_oe |-> data[31:16] == 16'h0)
    else $error("upper data lines not zero");

  c_read_68k: cover property (m && rw && data_size_ack == 2'h0);
  c_write_x86: cover property (!m && rw && !ready_out_n);
  c_master_ack: cover property (master_active && $fell(slave_mem_ack_n));
endmodule
`default_nettype wire

// File: sim/srap_bench.sv
// Purpose: host and device ends joined, user sides checked
// Assumes: mclk 10 MHz, inputs change on falling edge
// Notes: register file is an address echo, hence cheap
`timescale 1ns/1ps
`default_nettype none
module srap_bench;
  import srap_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 6'h0;
  logic [DATA_W-1:0] req_wdata = 16'h0;
  logic master_active = 1'b0;
  logic master_release = 1'b0;
  logic busy, done, wr_stb;
  logic [DATA_W-1:0] rdata, wr_data, rd_data;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  int mismatches = 0;
  int n_checks = 0;
  int n_wr = 0;
  srap_if u_srap_if ();
  always #50 mclk = ~mclk;
  assign rd_data = {10'h2a5, rd_addr};
  always @(posedge mclk) if (wr_stb) n_wr++;
  srap_host u_srap_host (.mclk(mclk), .rstn(rstn), .ce(1'b1),
    .bus(u_srap_if.host), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata));
  srap_device u_srap_device (.mclk(mclk), .rstn(rstn), .ce(1'b1),
    .bus(u_srap_if.device), .master_active(master_active),
    .master_release(master_release), .rd_addr(rd_addr),
    .rd_data(rd_data), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data));
  srap_properties u_srap_properties (.mclk(mclk), .rstn(rstn),
    .master_active(master_active),
    .bus_protocol_select(u_srap_if.bus_protocol_select),
    .cs_n(u_srap_if.cs_n), .slave_addr_strobe(u_srap_if.slave_addr_strobe),
    .rw(u_srap_if.rw), .data(u_srap_if.data),
    .dev_data_oe(u_srap_if.dev_data_oe),
    .slave_mem_ack_n(u_srap_if.slave_mem_ack_n),
    .dsack_oe(u_srap_if.dsack_oe),
    .data_size_ack(u_srap_if.data_size_ack),
    .ready_out_n(u_srap_if.ready_out_n));

  task automatic check(input logic [DATA_W-1:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hold > 0: master frees the bus only after that many clocks
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int hold);
    int t;
    int w;
    t = 0;
    w = n_wr;
    while (busy !== 1'b0) @(negedge mclk);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req = 1'b0;
    while (done !== 1'b1 && t < 80)
    begin
      @(negedge mclk);
      t++;
      if (t == hold) master_release = 1'b1;
    end
    master_release = 1'b0;
    check(t < 80, 1'b1);
    if (hold > 0) check(t > hold, 1'b1);
    if (wr)
    begin
      check(16'(n_wr), 16'(w + 1));
      check({wr_addr, wr_data[9:0]}, {a, d[9:0]});
      check(wr_data, d);
    end
    else
      check(rdata, {10'h2a5, a});
  endtask

  task automatic run_mode(input logic mode);
    @(negedge mclk);
    rstn = 1'b0;
    u_srap_if.bus_protocol_select = mode;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    access(1'b1, 6'h3f, 16'hffff, 0);
    access(1'b0, 6'h00, 16'h0000, 0);
    access(1'b1, 6'h00, 16'h8001, 0);
    access(1'b0, 6'h3f, 16'h0000, 0);
    master_active = 1'b1;
    access(1'b0, 6'h2a, 16'h0000, 6);
    access(1'b1, 6'h15, 16'h1234, 9);
    master_active = 1'b0;
    $display("mode %0d test done, mismatches %0d", mode, mismatches);
  endtask

  initial
  begin
    u_srap_if.bus_protocol_select = 1'b1;
    run_mode(1'b1);
    run_mode(1'b0);
    give_verdict();
  end

  // about 220 clocks expected; 5000, over twenty times that, is a hang
  initial
  begin
    #500000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
